// >>> hdl/blf_consts.svh
// constants for the backlight fade and daylight maximum-current block
// assumes inclusion by bare name from design and bench files
`ifndef BLF_CONSTS_SVH
`define BLF_CONSTS_SVH

// register offsets on the serial link
`define BLF_REG_MAX_CURRENT   8'h0a
`define BLF_REG_FADE_RATES    8'h09
// arbitrary link address, not tied to any part
`define BLF_DEV_ADDR          7'h2b

// field layout
`define BLF_MAX_CODE_MSB      6
`define BLF_FADE_IN_MSB       3
`define BLF_FADE_OUT_LSB      4
`define BLF_MAX_RESET         8'h00
`define BLF_FADE_RESET        8'h00

// full-scale fade times in ms
`define BLF_FS_FAST_MS        100
`define BLF_FS_STEP_MS        300
`define BLF_FS_KNEE_CODE      10
`define BLF_FS_KNEE_MS        3000
`define BLF_FS_LONG_STEP_MS   500
// codes from zero to full scale
`define BLF_CODE_STEPS        127
// clock rate in kHz: cycles per ms
`define BLF_CLK_KHZ           50000

`endif

// >>> hdl/blf_pkg.sv
// types shared by the backlight fade block
// assumes nothing beyond a SystemVerilog compiler
package blf_pkg;
	typedef enum logic [2:0] {
		BLF_IDLE,
		BLF_ADDR,
		BLF_REG,
		BLF_WR,
		BLF_RD
	} blf_link_st_t;
endpackage

// >>> hdl/blf_i2c_slave.sv
// serial two-wire register slave for the backlight fade block
// assumes scl and sda are pins of another domain; sda is open drain
`timescale 1ns/10ps
`default_nettype none
`include "blf_consts.svh"

module blf_i2c_slave
	import blf_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// link pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// register side
	output logic            wr_en,
	output logic [7:0]      reg_ptr,
	output logic [7:0]      wr_data,
	input  wire logic [7:0] rd_data
);

	logic [1:0]   scl_sync_q, sda_sync_q;
	logic         scl_p_q, sda_p_q;
	blf_link_st_t st_q, st_d;
	logic [3:0]   cnt_q, cnt_d;
	logic [7:0]   sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, wd_q, wd_d;
	logic         oe_q, oe_d, rw_q, rw_d, nack_q, nack_d, wr_q, wr_d;
	logic         lead_q, lead_d;
	logic         scl_s, sda_s, start, stop, rise, fall;

	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];
	assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign rise  = scl_s & ~scl_p_q;
	assign fall  = ~scl_s & scl_p_q;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sh_d   = sh_q;
		tx_d   = tx_q;
		ptr_d  = ptr_q;
		wd_d   = wd_q;
		oe_d   = oe_q;
		rw_d   = rw_q;
		nack_d = nack_q;
		lead_d = lead_q;
		wr_d   = 1'b0;
		if (start) begin
			st_d   = BLF_ADDR;
			cnt_d  = 4'h0;
			oe_d   = 1'b0;
			lead_d = 1'b1;
		end else if (stop) begin
			st_d   = BLF_IDLE;
			oe_d   = 1'b0;
			lead_d = 1'b0;
		end else if (st_q != BLF_IDLE) begin
			if (rise && cnt_q < 4'h8)
				sh_d = {sh_q[6:0], sda_s};
			if (rise && cnt_q == 4'h8 && st_q == BLF_RD) begin
				nack_d = sda_s;
				if (!sda_s)
					ptr_d = ptr_q + 8'h01;
			end
			// the scl fall that closes a start carries no bit; counting it
			// would shift the whole first byte by one
			if (fall && lead_q)
				lead_d = 1'b0;
			else if (fall) begin
				if (cnt_q < 4'h7) begin
					cnt_d = cnt_q + 4'h1;
					if (st_q == BLF_RD) begin
						oe_d = ~tx_q[6];
						tx_d = {tx_q[6:0], 1'b0};
					end
				end else if (cnt_q == 4'h7) begin
					cnt_d = 4'h8;
					oe_d  = 1'b1;
					unique case (st_q)
						BLF_ADDR: begin
							if (sh_q[7:1] != `BLF_DEV_ADDR) begin
								st_d = BLF_IDLE;
								oe_d = 1'b0;
							end
							rw_d = sh_q[0];
						end
						BLF_REG: ptr_d = sh_q;
						BLF_WR: begin
							wr_d = 1'b1;
							wd_d = sh_q;
						end
						BLF_RD: oe_d = 1'b0;
						BLF_IDLE: oe_d = 1'b0;
					endcase
				end else begin
					cnt_d = 4'h0;
					oe_d  = 1'b0;
					unique case (st_q)
						BLF_ADDR: begin
							st_d = rw_q ? BLF_RD : BLF_REG;
							if (rw_q) begin
								oe_d = ~rd_data[7];
								tx_d = rd_data;
							end
						end
						BLF_REG: st_d = BLF_WR;
						BLF_WR: ptr_d = ptr_q + 8'h01;
						BLF_RD: begin
							if (nack_q)
								st_d = BLF_IDLE;
							else begin
								oe_d = ~rd_data[7];
								tx_d = rd_data;
							end
						end
						BLF_IDLE: st_d = BLF_IDLE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			scl_sync_q <= 2'b11;
			sda_sync_q <= 2'b11;
			scl_p_q    <= 1'b1;
			sda_p_q    <= 1'b1;
			st_q       <= BLF_IDLE;
			cnt_q      <= 4'h0;
			sh_q       <= 8'h00;
			tx_q       <= 8'h00;
			ptr_q      <= 8'h00;
			wd_q       <= 8'h00;
			oe_q       <= 1'b0;
			rw_q       <= 1'b0;
			nack_q     <= 1'b0;
			wr_q       <= 1'b0;
			lead_q     <= 1'b0;
			sda_o      <= 1'b0;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_i};
			sda_sync_q <= {sda_sync_q[0], sda_i};
			scl_p_q    <= scl_s;
			sda_p_q    <= sda_s;
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			sh_q       <= sh_d;
			tx_q       <= tx_d;
			ptr_q      <= ptr_d;
			wd_q       <= wd_d;
			oe_q       <= oe_d;
			rw_q       <= rw_d;
			nack_q     <= nack_d;
			wr_q       <= wr_d;
			lead_q     <= lead_d;
			sda_o      <= 1'b0;
		end
	end

	assign sda_oe  = oe_q;
	assign wr_en   = wr_q;
	assign reg_ptr = ptr_q;
	assign wr_data = wd_q;

endmodule
`default_nettype wire

// >>> hdl/blf_backlight_fade.sv
// backlight fade-rate and daylight maximum-current registers with ramp
// assumes the host programs registers over the two-wire link pins
// Operation
// - rate code zero skips programmed ramp but still ramps in about 100 ms
// - nonzero fade-in: turning on ramps current from present value to maximum
// - each rate code time is for a full 0 to 30 mA ramp
// - shorter spans between start and end finish proportionally sooner
// - fade-in code in bits 3:0, times 0.3 s per step to 3 s, then 0.5 s per step to 5.5 s
// - disabled fading still moves current over about 100 ms, never a step
// - max-current register at 0x0a: bit 7 reserved, bits 6:0 code
// - code maps to current by square law, 0 gives 0 mA, 127 gives 30 mA
// - fade-out code in bits 7:4; ramps down to off value at its rate
`timescale 1ns/10ps
`default_nettype none
`include "blf_consts.svh"

module blf_backlight_fade
	import blf_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `BLF_CLK_KHZ
)(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// two-wire register link
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	// backlight on request pin
	input  wire logic bl_on_i,
	// led dac drive
	output logic [6:0] dac_code,
	output logic       ramp_busy
);

	////////////////////////////////////////////////////////////////////////////////
	// register file
	logic       wr_en;
	logic [7:0] reg_ptr, wr_data, rd_data;
	logic [6:0] daylight_max_current_code_q, daylight_max_current_code_d;
	logic [7:0] backlight_fade_rates_q, backlight_fade_rates_d;

	blf_i2c_slave u_link (
		.clk     (clk),
		.rst_b   (rst_b),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.sda_o   (sda_o),
		.sda_oe  (sda_oe),
		.wr_en   (wr_en),
		.reg_ptr (reg_ptr),
		.wr_data (wr_data),
		.rd_data (rd_data)
	);

	// reserved bit 7 stores nothing and reads zero
	always_comb begin
		daylight_max_current_code_d = daylight_max_current_code_q;
		backlight_fade_rates_d      = backlight_fade_rates_q;
		if (wr_en && reg_ptr == `BLF_REG_MAX_CURRENT)
			daylight_max_current_code_d = wr_data[`BLF_MAX_CODE_MSB:0];
		if (wr_en && reg_ptr == `BLF_REG_FADE_RATES)
			backlight_fade_rates_d = wr_data;
		unique case (reg_ptr)
			`BLF_REG_MAX_CURRENT: rd_data = {1'b0, daylight_max_current_code_q};
			`BLF_REG_FADE_RATES:  rd_data = backlight_fade_rates_q;
			default:              rd_data = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// ramp engine

	// full-scale time of a rate code in ms
	function automatic int unsigned full_scale_ms(input logic [3:0] code);
		int unsigned n;
		n = 32'(code);
		if (n == 0)
			full_scale_ms = `BLF_FS_FAST_MS;
		else if (n <= `BLF_FS_KNEE_CODE)
			full_scale_ms = n * `BLF_FS_STEP_MS;
		else
			full_scale_ms = `BLF_FS_KNEE_MS + (n - `BLF_FS_KNEE_CODE) * `BLF_FS_LONG_STEP_MS;
	endfunction

	// per-code interval: full span of 127 codes takes the full time, so a
	// shorter span takes proportionally less
	function automatic int unsigned step_cycles(input logic [3:0] code);
		int unsigned c;
		c = (full_scale_ms(code) * MS_CYCLES) / `BLF_CODE_STEPS;
		step_cycles = (c == 0) ? 1 : c;
	endfunction

	logic [1:0]  on_sync_q;
	logic [6:0]  dac_q, dac_d, target;
	logic [31:0] tick_q, tick_d, interval_w;
	logic [3:0]  cur_rate;
	logic        busy_q, busy_d, step_now;

	// off value is zero; the dim level lives outside this block
	// a new max code mid-ramp only moves the target, the ramp is not restarted
	assign target   = on_sync_q[1] ? daylight_max_current_code_q : 7'h00;
	assign cur_rate = (dac_q < target) ? backlight_fade_rates_q[`BLF_FADE_IN_MSB:0] :
		backlight_fade_rates_q[7:`BLF_FADE_OUT_LSB];
	assign interval_w = step_cycles(cur_rate);
	assign step_now   = (tick_q >= interval_w - 32'h1);

	always_comb begin
		dac_d  = dac_q;
		tick_d = tick_q;
		busy_d = (dac_q != target);
		if (dac_q == target)
			tick_d = 32'h0;
		else if (step_now) begin
			tick_d = 32'h0;
			if (dac_q < target)
				dac_d = dac_q + 7'h01;
			else
				dac_d = dac_q - 7'h01;
		end else
			tick_d = tick_q + 32'h1;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			on_sync_q                   <= 2'b00;
			daylight_max_current_code_q <= 7'(`BLF_MAX_RESET);
			backlight_fade_rates_q      <= `BLF_FADE_RESET;
			dac_q                       <= 7'h00;
			tick_q                      <= 32'h0;
			busy_q                      <= 1'b0;
		end else begin
			on_sync_q                   <= {on_sync_q[0], bl_on_i};
			daylight_max_current_code_q <= daylight_max_current_code_d;
			backlight_fade_rates_q      <= backlight_fade_rates_d;
			dac_q                       <= dac_d;
			tick_q                      <= tick_d;
			busy_q                      <= busy_d;
		end
	end

	// code drives the square-law current dac directly: 0 is 0 mA, 127 is 30 mA
	assign dac_code  = dac_q;
	assign ramp_busy = busy_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_step_up;
		step_now && dac_q < target;
	endsequence
	sequence s_step_dn;
		step_now && dac_q > target;
	endsequence

	property p_rise_one;
		@(posedge clk) disable iff (!rst_b) s_step_up |=> dac_q == $past(dac_q) + 7'h01;
	endproperty
	a_rise_one: assert property (p_rise_one) else $error("ramp up missed a step");

	property p_fall_one;
		@(posedge clk) disable iff (!rst_b) s_step_dn |=> dac_q == $past(dac_q) - 7'h01;
	endproperty
	a_fall_one: assert property (p_fall_one) else $error("ramp down missed a step");

	property p_single_step;
		@(posedge clk) disable iff (!rst_b)
			$changed(dac_q) |-> (dac_q == $past(dac_q) + 7'h01 || dac_q == $past(dac_q) - 7'h01);
	endproperty
	a_single_step: assert property (p_single_step) else $error("dac jumped");

	property p_hold_target;
		@(posedge clk) disable iff (!rst_b) (dac_q == target) |=> $stable(dac_q);
	endproperty
	a_hold_target: assert property (p_hold_target) else $error("dac left target");

	property p_spacing;
		@(posedge clk) disable iff (!rst_b)
			($changed(dac_q) && interval_w > 32'h1) |=> $stable(dac_q);
	endproperty
	a_spacing: assert property (p_spacing) else $error("steps too close");

	property p_fast_off;
		@(posedge clk) disable iff (!rst_b)
			(cur_rate == 4'h0) |-> interval_w < step_cycles(4'h1);
	endproperty
	a_fast_off: assert property (p_fast_off) else $error("disabled fade too slow");

	property p_max_write;
		@(posedge clk) disable iff (!rst_b) (wr_en && reg_ptr == `BLF_REG_MAX_CURRENT)
			|=> daylight_max_current_code_q == $past(wr_data[6:0]);
	endproperty
	a_max_write: assert property (p_max_write) else $error("max code not stored");

	property p_reserved_zero;
		@(posedge clk) disable iff (!rst_b)
			(reg_ptr == `BLF_REG_MAX_CURRENT) |-> rd_data[7] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_slow_code;
		@(posedge clk) disable iff (!rst_b)
			(cur_rate == 4'hf) |-> interval_w > step_cycles(4'he);
	endproperty
	a_slow_code: assert property (p_slow_code) else $error("rate order broken");

	property p_busy_track;
		@(posedge clk) disable iff (!rst_b) 1'b1 |=> ramp_busy == $past(dac_q != target);
	endproperty
	a_busy_track: assert property (p_busy_track) else $error("busy flag wrong");

	property p_tick_idle;
		@(posedge clk) disable iff (!rst_b) (dac_q == target) |=> tick_q == 32'h0;
	endproperty
	a_tick_idle: assert property (p_tick_idle) else $error("interval count left running");

	property p_rate_write;
		@(posedge clk) disable iff (!rst_b) (wr_en && reg_ptr == `BLF_REG_FADE_RATES)
			|=> backlight_fade_rates_q == $past(wr_data);
	endproperty
	a_rate_write: assert property (p_rate_write) else $error("rate codes not stored");

endmodule
`default_nettype wire

// >>> test/blf_host_model.sv
// host-side two-wire master model for the backlight fade block
// assumes the bench resolves sda from both pull-down enables with a pull-up
`timescale 1ns/10ps
`default_nettype none
`include "blf_consts.svh"

module blf_host_model (
	// clock
	input  wire logic clk,
	// link
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask
	// scl low 6 and high 5 clk, above the 4 clk minimum the synchronisers need
	task automatic put_bit(input logic b, output logic r);
		hold(3);
		sda_low = !b;
		hold(3);
		scl = 1'b1;
		hold(5);
		r = sda;
		scl = 1'b0;
	endtask
	// also serves as repeated start, since sda is released before scl is raised
	task automatic start();
		hold(3);
		sda_low = 1'b0;
		hold(3);
		scl = 1'b1;
		hold(5);
		sda_low = 1'b1;
		hold(5);
		scl = 1'b0;
	endtask
	task automatic stop();
		hold(3);
		sda_low = 1'b1;
		hold(3);
		scl = 1'b1;
		hold(5);
		sda_low = 1'b0;
		hold(5);
	endtask
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]);
		put_bit(mack, ack);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       k0;
		logic       k1;
		logic       k2;
		start();
		xfer({`BLF_DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer(a, 1'b1, r, k1);
		xfer(d, 1'b1, r, k2);
		stop();
		ok = !(k0 | k1 | k2);
	endtask
	// master releases sda for the data byte and ends with a nack
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       k0;
		logic       k1;
		logic       k2;
		logic       k3;
		start();
		xfer({`BLF_DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer(a, 1'b1, r, k1);
		start();
		xfer({`BLF_DEV_ADDR, 1'b1}, 1'b1, r, k2);
		xfer(8'hff, 1'b1, d, k3);
		stop();
		ok = !(k0 | k1 | k2);
	endtask
	task automatic probe(input logic [6:0] a, output logic acked);
		logic [7:0] r;
		logic       k;
		start();
		xfer({a, 1'b0}, 1'b1, r, k);
		stop();
		acked = !k;
	endtask
endmodule
`default_nettype wire

// >>> test/tb_blf_backlight_fade.sv
// bench for the backlight fade block: registers over the link, then ramps
// assumes a pull-up on sda and the host model as the only link master
`timescale 1ns/10ps
`default_nettype none

module tb_blf_backlight_fade;
	localparam int MS = 10;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       bl_on = 1'b0;
	wire logic  scl;
	wire logic  host_low;
	wire logic  sda_o;
	wire logic  sda_oe;
	wire logic  sda;
	wire logic [6:0] dac_code;
	wire logic  ramp_busy;
	logic [7:0] d;
	logic       ok;
	int         n_errors = 0;
	int         samples_checked = 0;

	assign sda = !(host_low || (sda_oe && !sda_o));
	always #10 clk = !clk;

	blf_backlight_fade #(.MS_CYCLES(MS)) DUT (.clk(clk), .rst_b(rst_b), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .bl_on_i(bl_on),
		.dac_code(dac_code), .ramp_busy(ramp_busy));
	blf_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));

	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g,
		input int tol);
		logic hit;
		hit = (g + tol >= e) && (g <= e + tol);
		samples_checked++;
		if (hit !== 1'b1) begin
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
			n_errors++;
		end
	endtask
	function automatic int ivl(input int code);
		int fs;
		fs = (code == 0) ? 100 : (code <= 10) ? 300 * code : 3000 + 500 * (code - 10);
		ivl = (fs * MS / 127 < 1) ? 1 : fs * MS / 127;
	endfunction
	// slack of 8 clk covers the pin synchronisers and the first interval phase
	task automatic ramp(input logic on, input int from, input int to, input int code);
		logic [6:0] prev;
		int         n;
		int         bad;
		n = 0;
		bad = 0;
		prev = from[6:0];
		bl_on = on;
		while (dac_code !== to[6:0] && n < 20000) begin
			@(negedge clk);
			n++;
			if (dac_code !== prev && dac_code !== prev + 7'h01 && dac_code !== prev - 7'h01)
				bad++;
			if (n == 4)
				chk("busy", 16'h0001, {15'h0000, ramp_busy}, 0);
			prev = dac_code;
		end
		if (n >= 20000) begin
			n_errors++;
			tally_and_finish();
		end
		chk("ramp cycles", 16'((to > from ? to - from : from - to) * ivl(code)),
			16'(n), 8);
		chk("bad steps", 16'h0000, 16'(bad), 0);
		repeat (3) @(negedge clk);
		chk("busy end", 16'h0000, {15'h0000, ramp_busy}, 0);
		$display("ramp test done code %0d to %0d", code, to);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		chk("dac reset", 16'h0000, {9'h000, dac_code}, 0);
		chk("busy reset", 16'h0000, {15'h0000, ramp_busy}, 0);
		chk("sda drive reset", 16'h0000, {14'h0000, sda_oe, sda_o}, 0);
		host.rd_reg(8'h0a, d, ok);
		chk("rd ack", 16'h0001, {15'h0000, ok}, 0);
		chk("max reset", 16'h0000, {8'h00, d}, 0);
		host.rd_reg(8'h09, d, ok);
		chk("rates reset", 16'h0000, {8'h00, d}, 0);
		host.wr_reg(8'h0a, 8'h04, ok);
		chk("wr ack", 16'h0001, {15'h0000, ok}, 0);
		host.wr_reg(8'h09, 8'hf1, ok);
		host.rd_reg(8'h0a, d, ok);
		chk("max code", 16'h0004, {8'h00, d}, 0);
		host.rd_reg(8'h09, d, ok);
		chk("rates", 16'h00f1, {8'h00, d}, 0);
		host.rd_reg(8'h20, d, ok);
		chk("unmapped", 16'h0000, {8'h00, d}, 0);
		host.probe(7'h2c, ok);
		chk("foreign addr", 16'h0000, {15'h0000, ok}, 0);
		$display("register test done");
		ramp(1'b1, 0, 4, 1);
		ramp(1'b0, 4, 0, 15);
		host.wr_reg(8'h09, 8'h00, ok);
		host.wr_reg(8'h0a, 8'h7f, ok);
		ramp(1'b1, 0, 127, 0);
		ramp(1'b0, 127, 0, 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
